// ==== cmp_irq_pkg.sv ====
package cmp_irq_pkg;

    // =====================================================================
    // APB register map (byte addresses)
    // =====================================================================
    localparam logic [7:0] ADDR_CMP_CTRL    = 8'h00;  // comparator_control_reg
    localparam logic [7:0] ADDR_FLAG2       = 8'h04;  // periph_flag_reg2
    localparam logic [7:0] ADDR_ENABLE2     = 8'h08;  // periph_enable_reg2
    localparam logic [7:0] ADDR_IRQ_CTRL    = 8'h0C;  // irq_control_reg
    localparam logic [7:0] ADDR_CONV_CTRL1  = 8'h10;  // converter_control_reg1
    localparam logic [7:0] ADDR_SLEEP_CTRL  = 8'h14;  // sleep control/status
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;  // sticky event status
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1C;  // event mask

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int OUT_ONE_BIT      = 6;   // comparator_one_output
    localparam int OUT_TWO_BIT      = 7;   // comparator_two_output
    localparam int CFG_LSB          = 0;   // comparator_config_field 2:0
    localparam int CFG_W            = 3;
    localparam int CHANGE_FLAG_BIT  = 6;   // comparator_change_flag
    localparam int CHANGE_EN_BIT    = 6;   // comparator_change_enable
    localparam int PERIPH_EN_BIT    = 6;   // periph_irq_enable
    localparam int GLOBAL_EN_BIT    = 7;   // global_irq_enable
    localparam int PORT_ANALOG_CONFIG_LSB         = 0;   // port_analog_config 3:0
    localparam int PORT_ANALOG_CONFIG_W           = 4;
    localparam int SLEEP_BIT        = 0;
    localparam int EVT_CHANGE_BIT   = 0;
    localparam int EVT_WAKE_BIT     = 1;
    localparam int EVT_W            = 2;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [2:0] CFG_RESET     = 3'h7;   // Both comparators off
    localparam logic [2:0] CFG_OFF       = 3'h7;
    localparam logic [3:0] PORT_ANALOG_CONFIG_RESET    = 4'h0;   // All pins analog
    localparam logic [1:0] REF_RESET     = 2'h0;

    localparam int SYNC_STAGES = 3;

    typedef struct packed
    {
        logic       change_en;
        logic       periph_en;
        logic       global_en;
    } irq_enables_t;

endpackage

// ==== cmp_sync.sv ====
`timescale 1ns/1ps

// =====================================================================
// Three-stage input synchroniser with agreement filter
// =====================================================================
module cmp_sync
#(
    parameter int STAGES = 3
)
(
    input  wire logic clk,    // System clock
    input  wire logic reset,  // Synchronous reset
    input  wire logic din,    // Asynchronous input
    output logic      dout    // Filtered level
);

    logic [STAGES-1:0] sync_r;

    always_ff @(posedge clk)
    begin
        if (reset)
            sync_r <= '0;
        else
            sync_r <= {sync_r[STAGES-2:0], din};
    end

    // Change counts once last two stages agree
    always_ff @(posedge clk)
    begin
        if (reset)
            dout <= 1'b0;
        else if (sync_r[STAGES-1] == sync_r[STAGES-2])
            dout <= sync_r[STAGES-1];
    end

endmodule

// ==== cmp_change_irq.sv ====
`timescale 1ns/1ps

module comparator_change_interrupt
(
    input  wire logic        CLK,           // System clock, 125 MHz
    input  wire logic        RESET,         // Synchronous, active high
    input  wire logic        CMP_ONE_IN,    // Raw comparator one output
    input  wire logic        CMP_TWO_IN,    // Raw comparator two output
    input  wire logic [7:0]  PADDR,         // APB address
    input  wire logic        PSEL,          // APB select
    input  wire logic        PENABLE,       // APB enable
    input  wire logic        PWRITE,        // APB direction
    input  wire logic [31:0] PWDATA,        // APB write data
    output logic [31:0]      PRDATA,        // APB read data
    output logic             PREADY,        // APB ready
    output logic             PSLVERR,       // APB error
    output logic             IRQ_REQ,       // Comparator interrupt request
    output logic             WAKE_REQ,      // Wake-up from sleep
    output logic             CMP_ENABLE,    // Comparators powered
    output logic [3:0]       PORT_CFG,      // Port analog configuration
    output logic             IRQ            // Masked sticky event interrupt
);

    // =====================================================================
    // Synchronised comparator outputs
    // =====================================================================
    logic [1:0] live_out;

    cmp_sync #(.STAGES(cmp_irq_pkg::SYNC_STAGES)) u_sync_one
    (
        .clk   (CLK),
        .reset (RESET),
        .din   (CMP_ONE_IN),
        .dout  (live_out[0])
    );

    cmp_sync #(.STAGES(cmp_irq_pkg::SYNC_STAGES)) u_sync_two
    (
        .clk   (CLK),
        .reset (RESET),
        .din   (CMP_TWO_IN),
        .dout  (live_out[1])
    );

    // =====================================================================
    // APB decode
    // =====================================================================
    logic        access;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        ctrl_access;

    assign access      = PSEL && PENABLE && PREADY;
    assign wr_en       = access && PWRITE;
    assign rd_en       = access && !PWRITE;
    assign addr_ok     = (PADDR == cmp_irq_pkg::ADDR_CMP_CTRL)   || (PADDR == cmp_irq_pkg::ADDR_FLAG2)
                      || (PADDR == cmp_irq_pkg::ADDR_ENABLE2)    || (PADDR == cmp_irq_pkg::ADDR_IRQ_CTRL)
                      || (PADDR == cmp_irq_pkg::ADDR_CONV_CTRL1) || (PADDR == cmp_irq_pkg::ADDR_SLEEP_CTRL)
                      || (PADDR == cmp_irq_pkg::ADDR_IRQ_STATUS) || (PADDR == cmp_irq_pkg::ADDR_IRQ_MASK);
    assign ctrl_access = access && (PADDR == cmp_irq_pkg::ADDR_CMP_CTRL);

    // Ready in the second access cycle
    always_ff @(posedge CLK)
    begin
        if (RESET)
            PREADY <= 1'b0;
        else
            PREADY <= PSEL && PENABLE && !PREADY;
    end

    // =====================================================================
    // Registers
    // =====================================================================
    logic [2:0]                cfg_r;
    logic [3:0]                port_analog_config_r;
    logic                      change_flag_r;
    logic                      sleep_r;
    logic [1:0]                ref_r;
    logic [cmp_irq_pkg::EVT_W-1:0] status_r;
    logic [cmp_irq_pkg::EVT_W-1:0] mask_r;
    cmp_irq_pkg::irq_enables_t en_r;
    logic                      mismatch;
    logic                      wake_evt;
    logic                      req_nxt;

    // Control register: only software writes it; sleep exit never touches it
    always_ff @(posedge CLK)
    begin
        if (RESET)
            cfg_r <= cmp_irq_pkg::CFG_RESET;
        else if (wr_en && PADDR == cmp_irq_pkg::ADDR_CMP_CTRL)
            cfg_r <= PWDATA[cmp_irq_pkg::CFG_LSB +: cmp_irq_pkg::CFG_W];
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            port_analog_config_r <= cmp_irq_pkg::PORT_ANALOG_CONFIG_RESET;
        else if (wr_en && PADDR == cmp_irq_pkg::ADDR_CONV_CTRL1)
            port_analog_config_r <= PWDATA[cmp_irq_pkg::PORT_ANALOG_CONFIG_LSB +: cmp_irq_pkg::PORT_ANALOG_CONFIG_W];
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            en_r <= '0;
        else
        begin
            if (wr_en && PADDR == cmp_irq_pkg::ADDR_ENABLE2)
                en_r.change_en <= PWDATA[cmp_irq_pkg::CHANGE_EN_BIT];
            if (wr_en && PADDR == cmp_irq_pkg::ADDR_IRQ_CTRL)
            begin
                en_r.periph_en <= PWDATA[cmp_irq_pkg::PERIPH_EN_BIT];
                en_r.global_en <= PWDATA[cmp_irq_pkg::GLOBAL_EN_BIT];
            end
        end
    end

    // Sleep is entered by software, left on a wake request
    always_ff @(posedge CLK)
    begin
        if (RESET)
            sleep_r <= 1'b0;
        else if (WAKE_REQ)
            sleep_r <= 1'b0;
        else if (wr_en && PADDR == cmp_irq_pkg::ADDR_SLEEP_CTRL)
            sleep_r <= PWDATA[cmp_irq_pkg::SLEEP_BIT];
    end

    // =====================================================================
    // Mismatch detection
    // =====================================================================
    // Control register access reloads the reference; a change in that cycle is absorbed
    always_ff @(posedge CLK)
    begin
        if (RESET)
            ref_r <= cmp_irq_pkg::REF_RESET;
        else if (ctrl_access)
            ref_r <= live_out;
    end

    // Comparators off means no mismatch
    assign mismatch = (live_out != ref_r) && (cfg_r != cmp_irq_pkg::CFG_OFF) && !ctrl_access;

    // Sticky flag; hardware set wins over software clear
    always_ff @(posedge CLK)
    begin
        if (RESET)
            change_flag_r <= 1'b0;
        else if (mismatch)
            change_flag_r <= 1'b1;
        else if (wr_en && PADDR == cmp_irq_pkg::ADDR_FLAG2)
            change_flag_r <= PWDATA[cmp_irq_pkg::CHANGE_FLAG_BIT];
    end

    // =====================================================================
    // Request and wake-up
    // =====================================================================
    assign req_nxt  = change_flag_r && en_r.change_en && en_r.periph_en && en_r.global_en;
    assign wake_evt = sleep_r && change_flag_r && en_r.change_en && !WAKE_REQ;

    always_ff @(posedge CLK)
    begin
        if (RESET)
            IRQ_REQ <= 1'b0;
        else
            IRQ_REQ <= req_nxt;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            WAKE_REQ <= 1'b0;
        else
            WAKE_REQ <= wake_evt;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            CMP_ENABLE <= 1'b0;
            PORT_CFG   <= cmp_irq_pkg::PORT_ANALOG_CONFIG_RESET;
        end
        else
        begin
            CMP_ENABLE <= (cfg_r != cmp_irq_pkg::CFG_OFF);
            PORT_CFG   <= port_analog_config_r;
        end
    end

    // =====================================================================
    // Sticky event status, mask, interrupt
    // =====================================================================
    logic [cmp_irq_pkg::EVT_W-1:0] evt;
    logic [cmp_irq_pkg::EVT_W-1:0] w1c;

    assign evt = {wake_evt, mismatch && !change_flag_r};
    assign w1c = (wr_en && PADDR == cmp_irq_pkg::ADDR_IRQ_STATUS) ? PWDATA[cmp_irq_pkg::EVT_W-1:0] : '0;

    always_ff @(posedge CLK)
    begin
        if (RESET)
            status_r <= '0;
        else
            status_r <= (status_r & ~w1c) | evt;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            mask_r <= '0;
        else if (wr_en && PADDR == cmp_irq_pkg::ADDR_IRQ_MASK)
            mask_r <= PWDATA[cmp_irq_pkg::EVT_W-1:0];
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            IRQ <= 1'b0;
        else
            IRQ <= |(((status_r & ~w1c) | evt) & mask_r);
    end

    // =====================================================================
    // Read data
    // =====================================================================
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (PADDR)
            cmp_irq_pkg::ADDR_CMP_CTRL:
            begin
                rd_mux[cmp_irq_pkg::OUT_ONE_BIT] = live_out[0];
                rd_mux[cmp_irq_pkg::OUT_TWO_BIT] = live_out[1];
                rd_mux[cmp_irq_pkg::CFG_LSB +: cmp_irq_pkg::CFG_W] = cfg_r;
            end
            cmp_irq_pkg::ADDR_FLAG2:      rd_mux[cmp_irq_pkg::CHANGE_FLAG_BIT] = change_flag_r;
            cmp_irq_pkg::ADDR_ENABLE2:    rd_mux[cmp_irq_pkg::CHANGE_EN_BIT] = en_r.change_en;
            cmp_irq_pkg::ADDR_IRQ_CTRL:
            begin
                rd_mux[cmp_irq_pkg::PERIPH_EN_BIT] = en_r.periph_en;
                rd_mux[cmp_irq_pkg::GLOBAL_EN_BIT] = en_r.global_en;
            end
            cmp_irq_pkg::ADDR_CONV_CTRL1: rd_mux[cmp_irq_pkg::PORT_ANALOG_CONFIG_LSB +: cmp_irq_pkg::PORT_ANALOG_CONFIG_W] = port_analog_config_r;
            cmp_irq_pkg::ADDR_SLEEP_CTRL: rd_mux[cmp_irq_pkg::SLEEP_BIT] = sleep_r;
            cmp_irq_pkg::ADDR_IRQ_STATUS: rd_mux[cmp_irq_pkg::EVT_W-1:0] = status_r;
            cmp_irq_pkg::ADDR_IRQ_MASK:   rd_mux[cmp_irq_pkg::EVT_W-1:0] = mask_r;
            default:                      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PRDATA  <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rd_mux : 32'h0000_0000;
            PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok;
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    a_flag_sets: assert property (@(posedge CLK) disable iff (RESET)
        mismatch |=> change_flag_r)
        else $error("change flag not set on mismatch");

    a_flag_sticky: assert property (@(posedge CLK) disable iff (RESET)
        (change_flag_r && !(wr_en && PADDR == cmp_irq_pkg::ADDR_FLAG2)) |=> change_flag_r)
        else $error("change flag cleared without software write");

    a_sw_set: assert property (@(posedge CLK) disable iff (RESET)
        (wr_en && PADDR == cmp_irq_pkg::ADDR_FLAG2 && PWDATA[cmp_irq_pkg::CHANGE_FLAG_BIT]) |=> change_flag_r)
        else $error("software set of change flag lost");

    a_req_gate: assert property (@(posedge CLK) disable iff (RESET)
        IRQ_REQ == $past(change_flag_r && en_r.change_en && en_r.periph_en && en_r.global_en))
        else $error("interrupt request does not follow enables");

    a_flag_noen: assert property (@(posedge CLK) disable iff (RESET)
        (mismatch && !en_r.global_en) |=> (change_flag_r && !IRQ_REQ))
        else $error("flag not set while disabled");

    a_ref_reload: assert property (@(posedge CLK) disable iff (RESET)
        ctrl_access |=> (ref_r == $past(live_out)))
        else $error("reference not reloaded on access");

    a_wake_req: assert property (@(posedge CLK) disable iff (RESET)
        (sleep_r && change_flag_r && en_r.change_en) |-> ##[0:1] WAKE_REQ ##1 !sleep_r)
        else $error("no wake-up from sleep");

    a_cfg_kept: assert property (@(posedge CLK) disable iff (RESET)
        ($fell(sleep_r) && !$past(wr_en && PADDR == cmp_irq_pkg::ADDR_CMP_CTRL)) |-> $stable(cfg_r))
        else $error("control register changed on wake");

    a_reset_cfg: assert property (@(posedge CLK)
        RESET |=> (cfg_r == cmp_irq_pkg::CFG_RESET && port_analog_config_r == cmp_irq_pkg::PORT_ANALOG_CONFIG_RESET))
        else $error("reset values not loaded");

endmodule

// ==== cmp_source.sv ====
`timescale 1ns/1ps

// =====================================================================
// Comparator pair model: toggles an output some cycles after a request
// =====================================================================
module cmp_source
(
    input  wire logic       clk,      // System clock
    input  wire logic [1:0] flip,     // Toggle request, one bit each
    input  wire logic [3:0] lag,      // Settling delay in cycles
    output logic            out_one,  // Comparator one level
    output logic            out_two   // Comparator two level
);
    logic [1:0] pend;
    logic [3:0] cnt;

    initial
    begin
        out_one = 1'b0;
        out_two = 1'b0;
        pend    = 2'h0;
        cnt     = 4'h0;
    end

    always @(posedge clk)
    begin
        if (flip != 2'h0)
        begin
            pend <= flip;
            cnt  <= lag;
        end
        else if (pend != 2'h0)
        begin
            if (cnt == 4'h0)
            begin
                out_one <= out_one ^ pend[0];
                out_two <= out_two ^ pend[1];
                pend    <= 2'h0;
            end
            else
                cnt <= cnt - 4'h1;
        end
    end
endmodule

// ==== comparator_change_interrupt_test.sv ====
`timescale 1ns/1ps

module comparator_change_interrupt_test;
    logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, one, two;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic PREADY, PSLVERR, IRQ_REQ, WAKE_REQ, CMP_ENABLE, IRQ, e;
    logic [3:0] PORT_CFG, lag = 4'h0, pc;
    logic [1:0] flip = 2'h0;
    int errors = 0, tests_run = 0, n;

    always #4 CLK = ~CLK;

    cmp_source src_u (.clk(CLK), .flip(flip), .lag(lag), .out_one(one), .out_two(two));

    comparator_change_interrupt dut_u (.CLK(CLK), .RESET(RESET), .CMP_ONE_IN(one), .CMP_TWO_IN(two),
        .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ_REQ(IRQ_REQ),
        .WAKE_REQ(WAKE_REQ), .CMP_ENABLE(CMP_ENABLE), .PORT_CFG(PORT_CFG), .IRQ(IRQ));

    // =====================================================================
    // Reporting
    // =====================================================================
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // =====================================================================
    // Bus and stimulus helpers
    // =====================================================================
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PADDR   <= a;
        PWRITE  <= wr;
        PWDATA  <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        q = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1)
        begin
            errors++;
            summarize();
        end
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask

    task automatic toggle(input logic [1:0] f);
        @(posedge CLK);
        flip <= f;
        lag  <= 4'($urandom_range(0, 3));
        @(posedge CLK);
        flip <= 2'h0;
        repeat (14) @(posedge CLK);
    endtask

    function automatic logic [31:0] irq_ctl(input logic [2:0] en);
        return {24'h0, en[2], en[1], 6'h0};
    endfunction

    // =====================================================================
    // Scenarios
    // =====================================================================
    initial
    begin
        void'($urandom(32'hD4C1B613));
        repeat (12) @(posedge CLK);
        RESET <= 1'b0;
        rd("ctrl reset", 8'h00, 32'h7);
        check("cmp enable", 32'(CMP_ENABLE), 32'h0);
        check("port cfg", 32'(PORT_CFG), 32'h0);
        rd("flag reset", 8'h04, 32'h0);
        $display("test reset done");

        apb(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge CLK);
        check("cmp on", 32'(CMP_ENABLE), 32'h1);
        toggle(2'b01);
        rd("flag one", 8'h04, 32'h40);
        check("no req", 32'(IRQ_REQ), 32'h0);
        rd("outs one", 8'h00, 32'h40);
        apb(1'b1, 8'h04, 32'h0);
        rd("flag clr", 8'h04, 32'h0);
        toggle(2'b10);
        apb(1'b1, 8'h04, 32'h0);
        rd("mismatch holds", 8'h04, 32'h40);
        rd("outs both", 8'h00, 32'hC0);
        apb(1'b1, 8'h04, 32'h0);
        repeat (4) @(posedge CLK);
        rd("flag clr2", 8'h04, 32'h0);
        $display("test change done");

        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 8'h08, 32'(i[0]) << 6);
            apb(1'b1, 8'h0C, irq_ctl(3'(i)));
            apb(1'b1, 8'h04, 32'h40);
            repeat (3) @(posedge CLK);
            check("irq req", 32'(IRQ_REQ), 32'(i == 7));
            apb(1'b1, 8'h04, 32'h0);
        end
        $display("test enables done");

        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h08, 32'h40);
        apb(1'b1, 8'h14, 32'h1);
        @(posedge CLK);
        flip <= 2'b01;
        @(posedge CLK);
        flip <= 2'b00;
        n = 0;
        while (WAKE_REQ !== 1'b1 && n < 40)
        begin
            @(posedge CLK);
            n++;
        end
        check("wake seen", 32'(n < 40), 32'h1);
        if (n >= 40)
            summarize();
        repeat (2) @(posedge CLK);
        rd("sleep clr", 8'h14, 32'h0);
        rd("ctrl kept", 8'h00, 32'h80);
        rd("status", 8'h18, 32'h3);
        apb(1'b1, 8'h1C, 32'h3);
        repeat (2) @(posedge CLK);
        check("irq on", 32'(IRQ), 32'h1);
        apb(1'b1, 8'h18, 32'h3);
        repeat (2) @(posedge CLK);
        check("irq off", 32'(IRQ), 32'h0);
        $display("test sleep done");

        pc = 4'($urandom());
        apb(1'b1, 8'h10, {28'h0, pc});
        repeat (2) @(posedge CLK);
        check("port cfg set", 32'(PORT_CFG), 32'(pc));
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped err", 32'(e), 32'h1);
        check("unmapped data", q, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h7);
        repeat (2) @(posedge CLK);
        check("cmp off", 32'(CMP_ENABLE), 32'h0);
        toggle(2'b11);
        rd("off no flag", 8'h04, 32'h0);
        $display("test misc done");
        summarize();
    end
endmodule
